// file: shared/pcp_pkg.sv
// shared constants and types for the program checksum and protect block
package pcp_pkg;

  // ************************************
  // word widths and address map
  // ************************************
  localparam int PCP_WORD_W = 14;
  localparam int PCP_ADDR_W = 14;
  localparam int PCP_DATA_W = 8;
  localparam int PCP_SUM_W = 16;
  localparam logic [13:0] PCP_ID_BASE = 14'h2000;
  localparam logic [13:0] PCP_ID_LAST = 14'h2003;
  localparam logic [13:0] PCP_CFG_ADDR = 14'h2007;
  localparam logic [13:0] PCP_DMEM_BASE = 14'h2100;
  localparam int PCP_DMEM_WORDS = 64;
  localparam logic [13:0] PCP_DMEM_LAST = 14'h213f;

  // ************************************
  // masks and values after reset
  // ************************************
  localparam logic [13:0] PCP_CFG_MASK = 14'h3fff;
  localparam logic [13:0] PCP_BLANK_WORD = 14'h3fff;
  localparam logic [7:0] PCP_BLANK_BYTE = 8'hff;
  localparam logic [13:0] PCP_ID_MASK = 14'h000f;
  localparam int PCP_CP_LSB = 4;
  localparam int PCP_CP_MSB = 13;

  // ************************************
  // link gaps the programmer must keep
  // ************************************
  localparam real PCP_GAP_CMD_MS = 1.0;
  localparam real PCP_GAP_FALL_RISE_MS = 1.0;

  // ************************************
  // carried groups
  // ************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [13:0] addr;
    logic [13:0] data;
  } pcp_req_t;

  typedef struct packed {
    logic rd_valid;
    logic [13:0] rd_data;
    logic wr_done;
    logic wr_refused;
  } pcp_rsp_t;

endpackage : pcp_pkg

// file: hdl/pcp_protect.sv
// memory protection masking and checksum engine
`timescale 1ns/1ps
module pcp_protect
  import pcp_pkg::*;
#(
  parameter int PROG_WORDS = 1024,
  parameter bit FLASH_PART = 1'b1,
  // config word fixed at manufacture on the rom part
  parameter logic [13:0] ROM_CFG = PCP_BLANK_WORD
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // memory access from the programming front end
  input wire pcp_req_t REQ_I,
  output pcp_rsp_t RSP_O,
  // checksum engine
  input wire logic CK_START_I,
  output logic CK_BUSY_O,
  output logic CK_DONE_O,
  output logic [15:0] CK_SUM_O,
  // protection state
  output logic PROTECT_O
);

  localparam int PA_W = $clog2(PROG_WORDS);
  localparam logic [PA_W-1:0] PROG_TOP = PA_W'(PROG_WORDS - 1);

  typedef enum logic [1:0] {CK_IDLE, CK_PROG, CK_IDS, CK_CFG} pcp_ck_t;

  // ************************************
  // storage
  // ************************************
  logic [13:0] prog_mem [PROG_WORDS];
  logic [7:0] data_mem [PCP_DMEM_WORDS];
  logic [13:0] id_mem [4];
  logic [13:0] cfg_q;
  pcp_rsp_t rsp_q;
  pcp_ck_t ck_state_q;
  logic [PA_W-1:0] ck_addr_q;
  logic [15:0] ck_sum_q;
  logic ck_done_q;

  // ************************************
  // address decode
  // ************************************
  wire logic is_prog = REQ_I.addr < 14'(PROG_WORDS);
  wire logic is_id = REQ_I.addr >= PCP_ID_BASE && REQ_I.addr <= PCP_ID_LAST;
  wire logic is_cfg = REQ_I.addr == PCP_CFG_ADDR;
  wire logic is_dmem = REQ_I.addr >= PCP_DMEM_BASE &&
                       REQ_I.addr <= PCP_DMEM_LAST;
  wire logic [PA_W-1:0] prog_idx = REQ_I.addr[PA_W-1:0];
  wire logic [5:0] dmem_idx = REQ_I.addr[5:0];
  wire logic [1:0] id_idx = REQ_I.addr[1:0];
  // code protect bits all zero means protected
  wire logic protect = cfg_q[PCP_CP_MSB:PCP_CP_LSB] == '0;

  // ************************************
  // read masking and write permission
  // ************************************
  wire logic [13:0] prog_rd = (protect && FLASH_PART) ? 14'h0000 :
                              prog_mem[prog_idx];
  wire logic [7:0] dmem_rd = (protect && !FLASH_PART) ? PCP_BLANK_BYTE :
                             data_mem[dmem_idx];
  wire logic [13:0] rd_word = is_prog ? prog_rd :
                              is_id ? id_mem[id_idx] :
                              is_cfg ? cfg_q :
                              is_dmem ? {6'h00, dmem_rd} : 14'h0000;
  wire logic wr_prog_ok = FLASH_PART && !protect && is_prog;
  wire logic wr_dmem_ok = !protect && is_dmem;
  wire logic wr_cfg_ok = FLASH_PART && is_cfg;
  wire logic wr_id_ok = FLASH_PART && is_id;
  wire logic wr_ok = wr_prog_ok || wr_dmem_ok || wr_cfg_ok || wr_id_ok;
  wire logic wr_req = REQ_I.valid && REQ_I.write;
  wire logic rd_req = REQ_I.valid && !REQ_I.write;

  // ************************************
  // memory writes; memories blanked at reset, config word loaded with ROM_CFG on the rom part
  // ************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < PROG_WORDS; i++) prog_mem[i] <= PCP_BLANK_WORD;
      for (int i = 0; i < PCP_DMEM_WORDS; i++) data_mem[i] <= PCP_BLANK_BYTE;
      for (int i = 0; i < 4; i++) id_mem[i] <= PCP_BLANK_WORD;
      cfg_q <= FLASH_PART ? PCP_BLANK_WORD : ROM_CFG;
    end else if (wr_req && wr_ok) begin
      if (is_prog) prog_mem[prog_idx] <= REQ_I.data;
      if (is_dmem) data_mem[dmem_idx] <= REQ_I.data[7:0];
      if (is_id) id_mem[id_idx] <= REQ_I.data;
      if (is_cfg) cfg_q <= REQ_I.data;
    end
  end

  // ************************************
  // registered answer, one cycle after request
  // ************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rsp_q <= '0;
    end else begin
      rsp_q.rd_valid <= rd_req;
      rsp_q.rd_data <= rd_req ? rd_word : rsp_q.rd_data;
      rsp_q.wr_done <= wr_req && wr_ok;
      rsp_q.wr_refused <= wr_req && !wr_ok;
    end
  end

  // ************************************
  // checksum walk
  // ************************************
  wire logic [15:0] prog_term = 16'(prog_mem[ck_addr_q]);
  wire logic [15:0] id_term = 16'(id_mem[ck_addr_q[1:0]] & PCP_ID_MASK);
  wire logic [15:0] cfg_term = 16'(cfg_q & PCP_CFG_MASK);

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ck_state_q <= CK_IDLE;
      ck_addr_q <= '0;
      ck_sum_q <= 16'h0000;
      ck_done_q <= 1'b0;
    end else begin
      unique case (ck_state_q)
        CK_IDLE: begin
          if (CK_START_I) begin
            ck_sum_q <= 16'h0000;
            ck_addr_q <= '0;
            ck_done_q <= 1'b0;
            ck_state_q <= protect ? CK_IDS : CK_PROG;
          end
        end
        CK_PROG: begin
          ck_sum_q <= ck_sum_q + prog_term;
          ck_addr_q <= ck_addr_q + 1'b1;
          if (ck_addr_q == PROG_TOP) ck_state_q <= CK_CFG;
        end
        CK_IDS: begin
          ck_sum_q <= ck_sum_q + id_term;
          ck_addr_q <= ck_addr_q + 1'b1;
          if (ck_addr_q[1:0] == 2'h3) ck_state_q <= CK_CFG;
        end
        CK_CFG: begin
          ck_sum_q <= ck_sum_q + cfg_term;
          ck_done_q <= 1'b1;
          ck_state_q <= CK_IDLE;
        end
      endcase
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign RSP_O = rsp_q;
  assign CK_BUSY_O = ck_state_q != CK_IDLE;
  assign CK_DONE_O = ck_done_q;
  assign CK_SUM_O = ck_sum_q;
  assign PROTECT_O = protect;

  // ************************************
  // checks
  // ************************************
  sequence prot_prog_rd_s;
    REQ_I.valid && !REQ_I.write && is_prog && protect;
  endsequence

  prog_zero_read_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (FLASH_PART and prot_prog_rd_s) |=> RSP_O.rd_valid && RSP_O.rd_data == '0)
    else $error("protected program read not zero");

  prot_write_block_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    REQ_I.valid && REQ_I.write && protect && (is_prog || is_dmem)
    |=> RSP_O.wr_refused && !RSP_O.wr_done)
    else $error("protected write not refused");

  rom_data_ones_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    !FLASH_PART && rd_req && is_dmem && protect
    |=> RSP_O.rd_data == 14'h00ff)
    else $error("rom protected data read not all ones");

  cfg_true_read_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    rd_req && is_cfg |=> RSP_O.rd_data == cfg_q)
    else $error("config word read not true");

  id_write_ok_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    FLASH_PART && wr_req && is_id |=> RSP_O.wr_done)
    else $error("id write refused on flash part");

  cfg_write_ok_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    FLASH_PART && wr_req && is_cfg |=> RSP_O.wr_done)
    else $error("config write refused on flash part");

  rom_cfg_fixed_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    !FLASH_PART && wr_req && is_cfg |=> RSP_O.wr_refused)
    else $error("config write taken on rom part");

  sum_held_a: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    CK_DONE_O && !CK_START_I |=> CK_DONE_O && $stable(CK_SUM_O))
    else $error("checksum not held after done");

endmodule : pcp_protect

// file: verification/pcp_prog_model.sv
// programmer model issuing memory requests
`timescale 1ns/1ps
module pcp_prog_model
  import pcp_pkg::*;
(
  // clock and answer
  input wire logic clk_i,
  input wire pcp_rsp_t rsp_i,
  // request
  output pcp_req_t req_o
);
  initial req_o = '0;

  // one request per call; an idle cycle always follows it
  task automatic xfer(input logic wr, input logic [13:0] a,
                      input logic [13:0] d, output logic [13:0] rd,
                      output logic ok);
    @(negedge clk_i);
    req_o = '{valid: 1'b1, write: wr, addr: a, data: d};
    // taken at the rising edge; the answer stands for the next cycle
    @(negedge clk_i);
    rd = rsp_i.rd_data;
    ok = wr ? rsp_i.wr_done : rsp_i.rd_valid;
    // released lines show the inverse, not the old value
    req_o = '{valid: 1'b0, write: 1'b0, addr: ~a, data: ~d};
  endtask : xfer
endmodule : pcp_prog_model

// file: verification/program_checksum_protect_test.sv
// testbench for the protect and checksum block
`timescale 1ns/1ps
module program_checksum_protect_test;
  import pcp_pkg::*;
  localparam int PW = 512;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  pcp_req_t req;
  pcp_rsp_t rsp;
  logic busy, done, prot;
  logic [15:0] sum;
  logic [13:0] rd;
  logic ok;
  pcp_req_t req_r;
  pcp_rsp_t rsp_r;
  logic prot_r;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;

  // clock, 40 ns period
  always #20 clk = ~clk;

  pcp_protect #(.PROG_WORDS(PW), .FLASH_PART(1'b1)) uut (
    .CLK_I(clk), .SYS_RST_I(rst), .REQ_I(req), .RSP_O(rsp),
    .CK_START_I(start), .CK_BUSY_O(busy), .CK_DONE_O(done),
    .CK_SUM_O(sum), .PROTECT_O(prot));
  pcp_prog_model prog (.clk_i(clk), .rsp_i(rsp), .req_o(req));

  // rom part, config fixed with protection on
  pcp_protect #(.PROG_WORDS(PW), .FLASH_PART(1'b0),
    .ROM_CFG(14'h0000)) uut_rom (
    .CLK_I(clk), .SYS_RST_I(rst), .REQ_I(req_r), .RSP_O(rsp_r),
    .CK_START_I(start), .CK_BUSY_O(), .CK_DONE_O(),
    .CK_SUM_O(), .PROTECT_O(prot_r));
  pcp_prog_model prog_rom (.clk_i(clk), .rsp_i(rsp_r), .req_o(req_r));

  // compare one value
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // start a walk, time it, check the result and that it holds
  task run_sum(input logic [15:0] exp, input int lat);
    int n;
    n = 0;
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check(16'(done), 16'h0);
    while (done !== 1'b1 && n < lat + 5) begin
      @(negedge clk);
      n++;
    end
    check(16'(n), 16'(lat - 1));
    check(sum, exp);
    repeat (3) @(negedge clk);
    check({busy, done, 14'h0}, 16'h4000);
    check(sum, exp);
  endtask : run_sum

  // blank part, data byte, pattern at both ends of program memory
  task t_pattern;
    prog.xfer(1'b0, PCP_CFG_ADDR, 14'h0, rd, ok);
    check(16'(rd), 16'h3fff);
    check(16'(ok), 16'h1);
    check(16'(prot), 16'h0);
    prog.xfer(1'b1, PCP_DMEM_BASE, 14'h005a, rd, ok);
    prog.xfer(1'b0, PCP_DMEM_BASE, 14'h0, rd, ok);
    check(16'(rd), 16'h005a);
    prog.xfer(1'b1, 14'h0, 14'h25e6, rd, ok);
    prog.xfer(1'b1, 14'(PW - 1), 14'h25e6, rd, ok);
    run_sum(16'h09cd, PW + 2);
  endtask : t_pattern

  // import all data bytes from an image, then export and compare
  task t_image;
    logic [7:0] img [PCP_DMEM_WORDS];
    for (int i = 0; i < PCP_DMEM_WORDS; i++) img[i] = 8'(8'h5a ^ i);
    for (int i = 0; i < PCP_DMEM_WORDS; i++) begin
      prog.xfer(1'b1, PCP_DMEM_BASE + 14'(i), {6'h00, img[i]}, rd, ok);
      check(16'(ok), 16'h1);
    end
    for (int i = 0; i < PCP_DMEM_WORDS; i++) begin
      prog.xfer(1'b0, PCP_DMEM_BASE + 14'(i), 14'h0, rd, ok);
      check(16'(rd), 16'(img[i]));
    end
  endtask : t_image

  // protect, then check masking, refusals and the short sum
  task t_protect;
    prog.xfer(1'b1, PCP_ID_BASE, 14'h1234, rd, ok);
    prog.xfer(1'b1, PCP_CFG_ADDR, 14'h0007, rd, ok);
    check(16'(prot), 16'h1);
    prog.xfer(1'b0, 14'h0, 14'h0, rd, ok);
    check(16'(rd), 16'h0);
    prog.xfer(1'b1, 14'h0005, 14'h0123, rd, ok);
    check(16'(ok), 16'h0);
    check(16'(rsp.wr_refused), 16'h1);
    prog.xfer(1'b1, PCP_DMEM_BASE, 14'h0011, rd, ok);
    check(16'(ok), 16'h0);
    check(16'(rsp.wr_refused), 16'h1);
    prog.xfer(1'b0, PCP_CFG_ADDR, 14'h0, rd, ok);
    check(16'(rd), 16'h0007);
    prog.xfer(1'b0, PCP_ID_BASE, 14'h0, rd, ok);
    check(16'(rd), 16'h1234);
    prog.xfer(1'b1, 14'h2001, 14'h0002, rd, ok);
    check(16'(ok), 16'h1);
    run_sum(16'h002b, 6);
  endtask : t_protect

  // sum the protected readout directly, as a programmer may
  task t_readout;
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 0; i < PW; i++) begin
      prog.xfer(1'b0, 14'(i), 14'h0, rd, ok);
      acc = acc + 16'(rd);
    end
    for (int i = 0; i < 4; i++) begin
      prog.xfer(1'b0, PCP_ID_BASE + 14'(i), 14'h0, rd, ok);
      acc = acc + 16'(rd & PCP_ID_MASK);
    end
    prog.xfer(1'b0, PCP_CFG_ADDR, 14'h0, rd, ok);
    acc = acc + 16'(rd & PCP_CFG_MASK);
    check(acc, 16'h002b);
  endtask : t_readout

  // rom part: data reads all ones, data and config writes refused
  task t_rom;
    check(16'(prot_r), 16'h1);
    prog_rom.xfer(1'b1, PCP_DMEM_BASE, 14'h0011, rd, ok);
    check(16'(ok), 16'h0);
    check(16'(rsp_r.wr_refused), 16'h1);
    prog_rom.xfer(1'b0, PCP_DMEM_BASE, 14'h0, rd, ok);
    check(16'(rd), 16'h00ff);
    prog_rom.xfer(1'b1, PCP_CFG_ADDR, 14'h3fff, rd, ok);
    check(16'(ok), 16'h0);
    prog_rom.xfer(1'b0, PCP_CFG_ADDR, 14'h0, rd, ok);
    check(16'(rd), 16'h0000);
  endtask : t_rom

  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_pattern();
    t_image();
    t_protect();
    t_readout();
    t_rom();
    wrap_up();
  end
endmodule : program_checksum_protect_test
